// ### design/counter_pkg.sv
package counter_pkg;

   // Counter geometry
   localparam int          COUNT_W      = 4;

   // Register bus geometry
   localparam int          ADDR_W       = 5;
   localparam int          DATA_W       = 32;
   localparam int          STRB_W       = 4;
   localparam int          PRESCALE_W   = 16;
   localparam int          EVENT_W      = 16;

   // Register byte offsets
   localparam logic [4:0]  CTRL_OFS     = 5'h00;
   localparam logic [4:0]  PRESET_OFS   = 5'h04;
   localparam logic [4:0]  STATUS_OFS   = 5'h08;
   localparam logic [4:0]  PRESCALE_OFS = 5'h0c;
   localparam logic [4:0]  EVENTS_OFS   = 5'h10;

   // Control register fields
   localparam int          CTRL_CLEAR_N = 0;
   localparam int          CTRL_LOAD_N  = 1;
   localparam int          CTRL_EN_P    = 2;
   localparam int          CTRL_EN_T    = 3;
   localparam int          CTRL_RUN     = 4;
   localparam int          CTRL_STEP    = 5;
   localparam int          CTRL_W       = 5;

   // Status register fields
   localparam int          STAT_COUNT   = 0;
   localparam int          STAT_CARRY   = 4;
   localparam int          STAT_WRAP    = 8;

   // Reset values
   localparam logic [4:0]  CTRL_RST     = 5'h03;
   localparam logic [3:0]  PRESET_RST   = 4'h0;
   localparam logic [15:0] PRESCALE_RST = 16'h0000;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage : counter_pkg

// ### design/counter_if.sv
interface counter_if;
   import counter_pkg::*;

   logic               clearN;
   logic               loadN;
   logic               enP;
   logic               enT;
   logic               countEdge;
   logic [COUNT_W-1:0] presetData;
   logic [COUNT_W-1:0] count;
   logic               carry;

   modport ctl  (output clearN, loadN, enP, enT, countEdge, presetData,
                 input  count, carry);
   modport core (input  clearN, loadN, enP, enT, countEdge, presetData,
                 output count, carry);

endinterface : counter_if

// ### design/counter_core.sv
module counter_core #(
   parameter bit SYNC_CLEAR = 1'b1
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstLocal_n,
   // Controls and state
   counter_if.core   cnt
);
   import counter_pkg::*;

   typedef struct packed {
      logic [COUNT_W-1:0] count;
   } core_state_t;

   core_state_t state_reg;
   core_state_t state_next;
   logic        asyncClear;

   assign asyncClear = !SYNC_CLEAR && !cnt.clearN;

   always_comb begin
      state_next = state_reg;
      if (asyncClear) begin
         state_next.count = '0;
      end else if (cnt.countEdge) begin
         if (SYNC_CLEAR && !cnt.clearN) begin
            state_next.count = '0;
         end else if (!cnt.loadN) begin
            state_next.count = cnt.presetData;
         end else if (cnt.enP && cnt.enT) begin
            // All-ones rolls over to zero through the 4-bit truncation
            state_next.count = COUNT_W'(state_reg.count + 4'h1);
         end
      end
   end

   always_ff @(posedge clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // The asynchronous clear forces the outputs at once, ahead of the flops catching up
   assign cnt.count = asyncClear ? '0 : state_reg.count;
   // Decoded from stored bits only, so it cannot spike between edges
   assign cnt.carry = cnt.enT && (&cnt.count);

endmodule // counter_core

// ### design/counter_top.sv
// Behaviour
// - The counter keeps a four-bit binary state shown at all times.
// - All four state bits change together on one clock edge.
// - The count rises only with both enables high and no load or clear.
// - A low load at an edge copies the preset data, ignoring the enables.
// - A rising load transition alone never changes the state.
// - In the asynchronous variant a low clear zeroes the state at once.
// - In the synchronous variant a low clear zeroes the state at the edge.
// - Carry is gated by the trickle enable; the parallel enable has no say.
// - Carry is high for as long as the low bit at terminal count.
// - Carry is decoded from stored state and does not glitch.
// - Falling enables are accepted any time and change nothing alone.
// - Except for the asynchronous clear, mode is chosen only from control levels sampled at the edge.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
module counter_top
   import counter_pkg::*;
#(
   parameter bit SYNC_CLEAR = 1'b1
) (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // AXI4-Lite write address
   input  wire logic [counter_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [counter_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [counter_pkg::STRB_W-1:0] s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [counter_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   // AXI4-Lite read data
   output logic [counter_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // Counter outputs
   output logic [counter_pkg::COUNT_W-1:0] countOut,
   output logic                           rippleCarry
);
   import counter_pkg::*;

   typedef struct packed {
      // Write channel tracking
      logic                  awHave;
      logic [ADDR_W-1:0]     awAddr;
      logic                  wHave;
      logic [DATA_W-1:0]     wData;
      logic [STRB_W-1:0]     wStrb;
      logic                  bvalid;
      logic [1:0]            bresp;
      // Read channel
      logic                  rvalid;
      logic [DATA_W-1:0]     rdata;
      logic [1:0]            rresp;
      // Software registers
      logic [CTRL_W-1:0]     ctrl;
      logic [COUNT_W-1:0]    preset;
      logic [PRESCALE_W-1:0] prescale;
      // Edge generation
      logic [PRESCALE_W-1:0] div;
      logic                  stepPend;
      // Observation
      logic                  carryPrev;
      logic                  wrapFlag;
      logic [EVENT_W-1:0]    events;
   } top_state_t;

   top_state_t  state_reg;
   top_state_t  state_next;
   logic [1:0]  rstSync_reg;
   logic        rstLocal_n;

   counter_if   cnt ();

   // Byte-lane merge of a write into an existing word
   function automatic logic [DATA_W-1:0] mergeLanes(
      input logic [DATA_W-1:0] oldWord,
      input logic [DATA_W-1:0] newWord,
      input logic [STRB_W-1:0] strb
   );
      logic [DATA_W-1:0] res;
      res = oldWord;
      for (int i = 0; i < STRB_W; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = newWord[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // True when an address names a register
   function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
      logic hit;
      hit = 1'b0;
      case (addr)
         CTRL_OFS, PRESET_OFS, STATUS_OFS,
         PRESCALE_OFS, EVENTS_OFS: hit = 1'b1;
         default:                 hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync_reg <= 2'h0;
      end else begin
         rstSync_reg <= {rstSync_reg[0], 1'b1};
      end
   end

   assign rstLocal_n = rstSync_reg[1];

   // Controls reach the core only from stored register bits
   assign cnt.clearN     = state_reg.ctrl[CTRL_CLEAR_N];
   assign cnt.loadN      = state_reg.ctrl[CTRL_LOAD_N];
   assign cnt.enP        = state_reg.ctrl[CTRL_EN_P];
   assign cnt.enT        = state_reg.ctrl[CTRL_EN_T];
   assign cnt.presetData = state_reg.preset;
   assign cnt.countEdge  = state_reg.stepPend ||
                           (state_reg.ctrl[CTRL_RUN] &&
                            state_reg.div == state_reg.prescale);

   counter_core #(
      .SYNC_CLEAR (SYNC_CLEAR)
   ) core_i (
      .clk        (clk),
      .rstLocal_n (rstLocal_n),
      .cnt        (cnt)
   );

   always_comb begin
      logic                  awFire;
      logic                  wFire;
      logic                  arFire;
      logic                  doWrite;
      logic [ADDR_W-1:0]     wAddr;
      logic [DATA_W-1:0]     wWord;
      logic [DATA_W-1:0]     merged;
      logic                  clearWrap;
      logic                  carryRise;
      awFire    = 1'b0;
      wFire     = 1'b0;
      arFire    = 1'b0;
      doWrite   = 1'b0;
      wAddr     = '0;
      wWord     = '0;
      merged    = '0;
      clearWrap = 1'b0;
      carryRise = 1'b0;
      state_next = state_reg;

      // Write address and data may arrive in either order
      awFire = s_axi_awvalid && s_axi_awready;
      wFire  = s_axi_wvalid && s_axi_wready;
      if (awFire) begin
         state_next.awHave = 1'b1;
         state_next.awAddr = s_axi_awaddr;
      end
      if (wFire) begin
         state_next.wHave = 1'b1;
         state_next.wData = s_axi_wdata;
         state_next.wStrb = s_axi_wstrb;
      end
      doWrite = (state_reg.awHave || awFire) && (state_reg.wHave || wFire);
      wAddr   = state_reg.awHave ? state_reg.awAddr : s_axi_awaddr;
      wWord   = state_reg.wHave ? state_reg.wData : s_axi_wdata;

      // Step is a one-shot edge request; it never reads back
      if (cnt.countEdge) begin
         state_next.stepPend = 1'b0;
      end

      if (doWrite) begin
         state_next.awHave = 1'b0;
         state_next.wHave  = 1'b0;
         state_next.bvalid = 1'b1;
         state_next.bresp  = isMapped(wAddr) ? RESP_OKAY : RESP_SLVERR;
         merged = mergeLanes('0, wWord,
                             state_reg.wHave ? state_reg.wStrb : s_axi_wstrb);
         case (wAddr)
            CTRL_OFS: begin
               merged = mergeLanes(DATA_W'(state_reg.ctrl), wWord,
                  state_reg.wHave ? state_reg.wStrb : s_axi_wstrb);
               state_next.ctrl = merged[CTRL_W-1:0];
               if (merged[CTRL_STEP]) begin
                  state_next.stepPend = 1'b1;
               end
            end
            PRESET_OFS: begin
               merged = mergeLanes(DATA_W'(state_reg.preset), wWord,
                  state_reg.wHave ? state_reg.wStrb : s_axi_wstrb);
               state_next.preset = merged[COUNT_W-1:0];
            end
            STATUS_OFS: begin
               // Writing one to the wrap bit clears it
               clearWrap = merged[STAT_WRAP];
            end
            PRESCALE_OFS: begin
               merged = mergeLanes(DATA_W'(state_reg.prescale), wWord,
                  state_reg.wHave ? state_reg.wStrb : s_axi_wstrb);
               state_next.prescale = merged[PRESCALE_W-1:0];
            end
            EVENTS_OFS: begin
               // Any write restarts the carry event tally
               state_next.events = '0;
            end
            default: begin
               state_next.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (state_reg.bvalid && s_axi_bready) begin
         state_next.bvalid = 1'b0;
      end

      // Divider that paces counter edges at clk / (prescale + 1)
      if (!state_reg.ctrl[CTRL_RUN] || cnt.countEdge) begin
         state_next.div = '0;
      end else begin
         state_next.div = PRESCALE_W'(state_reg.div + 16'h0001);
      end

      // Carry pulses are tallied; a new one wins over a software clear
      carryRise = cnt.carry && !state_reg.carryPrev;
      state_next.carryPrev = cnt.carry;
      if (clearWrap) begin
         state_next.wrapFlag = 1'b0;
      end
      if (carryRise) begin
         state_next.wrapFlag = 1'b1;
         state_next.events = EVENT_W'(state_next.events + 16'h0001);
      end

      // Read channel
      arFire = s_axi_arvalid && s_axi_arready;
      if (arFire) begin
         state_next.rvalid = 1'b1;
         state_next.rresp  = isMapped(s_axi_araddr) ? RESP_OKAY
                                                    : RESP_SLVERR;
         case (s_axi_araddr)
            CTRL_OFS:     state_next.rdata = DATA_W'(state_reg.ctrl);
            PRESET_OFS:   state_next.rdata = DATA_W'(state_reg.preset);
            STATUS_OFS: begin
               state_next.rdata = '0;
               state_next.rdata[STAT_COUNT +: COUNT_W] = cnt.count;
               state_next.rdata[STAT_CARRY] = cnt.carry;
               state_next.rdata[STAT_WRAP]  = state_reg.wrapFlag;
            end
            PRESCALE_OFS: state_next.rdata = DATA_W'(state_reg.prescale);
            EVENTS_OFS:   state_next.rdata = DATA_W'(state_reg.events);
            default:      state_next.rdata = '0;
         endcase
      end else if (state_reg.rvalid && s_axi_rready) begin
         state_next.rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         state_reg          <= '0;
         state_reg.ctrl     <= CTRL_RST;
         state_reg.preset   <= PRESET_RST;
         state_reg.prescale <= PRESCALE_RST;
         state_reg.bresp    <= RESP_OKAY;
         state_reg.rresp    <= RESP_OKAY;
      end else begin
         state_reg <= state_next;
      end
   end

   // One transaction per channel; each ready drops while its answer waits
   assign s_axi_awready = !state_reg.awHave && !state_reg.bvalid;
   assign s_axi_wready  = !state_reg.wHave && !state_reg.bvalid;
   assign s_axi_bvalid  = state_reg.bvalid;
   assign s_axi_bresp   = state_reg.bresp;
   assign s_axi_arready = !state_reg.rvalid;
   assign s_axi_rvalid  = state_reg.rvalid;
   assign s_axi_rdata   = state_reg.rdata;
   assign s_axi_rresp   = state_reg.rresp;

   assign countOut    = cnt.count;
   assign rippleCarry = cnt.carry;

endmodule // counter_top

// ### test/counter_sva.sv
module counter_sva
   import counter_pkg::*;
(
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      rst_n,
   // Bus handshakes
   input wire logic                      s_axi_awvalid,
   input wire logic                      s_axi_awready,
   input wire logic                      s_axi_wvalid,
   input wire logic                      s_axi_wready,
   input wire logic [1:0]                s_axi_bresp,
   input wire logic                      s_axi_bvalid,
   input wire logic                      s_axi_bready,
   input wire logic                      s_axi_arvalid,
   input wire logic                      s_axi_arready,
   input wire logic [counter_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0]                s_axi_rresp,
   input wire logic                      s_axi_rvalid,
   input wire logic                      s_axi_rready,
   // Counter outputs
   input wire logic [counter_pkg::COUNT_W-1:0] countOut,
   input wire logic                      rippleCarry
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence wrBoth;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rdTaken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   a_b_blocks_w:
   assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write ready while response pending");
   a_r_blocks_ar:
   assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read ready while data pending");
   a_b_answer:
   assert property (wrBoth |=> s_axi_bvalid)
      else $error("no write response");
   a_r_answer:
   assert property (rdTaken |=> s_axi_rvalid)
      else $error("no read data");
   a_b_holds:
   assert property (s_axi_bvalid && !s_axi_bready
                    |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_r_holds:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
                    && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped");
   a_r_release:
   assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data held after handshake");
   a_carry_full:
   assert property (rippleCarry |-> countOut == 4'hf)
      else $error("carry without terminal count");
endmodule // counter_sva

bind counter_top counter_sva chk_u (.*);

// ### test/cascade_stage.sv
module cascade_stage
   import counter_pkg::*;
(
   // Shared clock and carry from the stage below
   input wire logic                      clk,
   input wire logic                      carryIn,
   // Stage state
   output logic [counter_pkg::COUNT_W-1:0] stageCount
);
   timeunit 1ns;
   timeprecision 100ps;
   initial stageCount = 4'h0;
   // Same clock as the lower stage, so the chain never ripples
   always @(posedge clk) begin
      if (carryIn === 1'h1) stageCount <= stageCount + 4'h1;
   end
endmodule // cascade_stage

// ### test/presettable_binary_counter_4bit_tb_top.sv
module presettable_binary_counter_4bit_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import counter_pkg::*;
   logic                clk = 1'h0;
   logic                rst_n = 1'h0;
   logic [ADDR_W-1:0]   s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
   logic [DATA_W-1:0]   s_axi_wdata = 32'h0, s_axi_rdata;
   logic [STRB_W-1:0]   s_axi_wstrb = 4'h0;
   logic                s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic                s_axi_bready = 1'h0, s_axi_rready = 1'h0;
   logic                s_axi_arvalid = 1'h0;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic                s_axi_arready, s_axi_rvalid, rippleCarry;
   logic [1:0]          s_axi_bresp, s_axi_rresp, r;
   logic [COUNT_W-1:0]  countOut, stageCount, p, s0, countAsync;
   logic                carryAsync;
   // Decoded top count of the shortened sequence
   localparam logic [3:0] SHORT_MAX = 4'h2;
   logic [31:0]         d;
   int                  errTotal = 0, nTests = 0;

   counter_top dut_u (.*);
   cascade_stage st_u (.clk(clk), .carryIn(rippleCarry),
                       .stageCount(stageCount));
   // Asynchronous-clear build on the same bus; only its counter is watched
   counter_top #(.SYNC_CLEAR(1'b0)) dutAsync_u (
      .clk           (clk),
      .rst_n         (rst_n),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (),
      .s_axi_bresp   (),
      .s_axi_bvalid  (),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (),
      .s_axi_rdata   (),
      .s_axi_rresp   (),
      .s_axi_rvalid  (),
      .s_axi_rready  (s_axi_rready),
      .countOut      (countAsync),
      .rippleCarry   (carryAsync)
   );

   initial begin
      forever #2.5 clk = ~clk;
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         errTotal++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 100);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
      check(s_axi_bvalid, 1'h1);
   endtask

   task rd(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 100);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
      check(s_axi_rvalid, 1'h1);
   endtask

   // One control write, stepping one edge when bit 5 is set, then the settled count is compared
   task go(input logic [31:0] c, input logic [3:0] e);
      wr(CTRL_OFS, c, r);
      repeat (3) @(posedge clk);
      check(countOut, e);
   endtask

   task t_reset;
      rd(CTRL_OFS, d, r);
      check(d, 32'h3);
      check(r, RESP_OKAY);
      check(countOut, 4'h0);
      check(rippleCarry, 1'h0);
      $display("test reset done");
   endtask

   task t_load;
      wr(PRESET_OFS, 32'he, r);
      go(32'h21, 4'he);
      wr(PRESET_OFS, 32'h9, r);
      go(32'h2d, 4'h9);
      $display("test load done");
   endtask

   task t_count;
      go(32'h2b, 4'h9);
      go(32'h27, 4'h9);
      go(32'h2f, 4'ha);
      wr(PRESET_OFS, 32'hf, r);
      go(32'h21, 4'hf);
      go(32'h07, 4'hf);
      check(rippleCarry, 1'h0);
      go(32'h0b, 4'hf);
      check(rippleCarry, 1'h1);
      go(32'h2f, 4'h0);
      check(rippleCarry, 1'h0);
      $display("test count done");
   endtask

   task t_clear;
      go(32'h21, 4'hf);
      go(32'h2e, 4'h0);
      go(32'h21, 4'hf);
      go(32'h20, 4'h0);
      rd(STATUS_OFS, d, r);
      check(d[3:0], 4'h0);
      $display("test clear done");
   endtask

   // Outside logic clears at a decoded count to shorten the sequence
   task t_short;
      wr(PRESET_OFS, 32'h0, r);
      go(32'h21, 4'h0);
      p = 4'h0;
      for (int i = 0; i < 6; i++) begin
         if (p == SHORT_MAX) begin
            p = 4'h0;
            go(32'h2e, p);
         end else begin
            p = 4'(p + 4'h1);
            go(32'h2f, p);
         end
      end
      $display("test short done");
   endtask

   // Clear low with no counter edge: only the asynchronous build zeroes
   task t_async;
      wr(PRESET_OFS, 32'h6, r);
      go(32'h21, 4'h6);
      check(countAsync, 4'h6);
      wr(CTRL_OFS, 32'h0e, r);
      @(negedge clk);
      check(countAsync, 4'h0);
      check(carryAsync, 1'h0);
      check(countOut, 4'h6);
      $display("test async done");
   endtask

   task t_bus;
      rd(5'h14, d, r);
      check(r, RESP_SLVERR);
      check(d, 32'h0);
      wr(5'h18, 32'h5, r);
      check(r, RESP_SLVERR);
      wr(PRESCALE_OFS, 32'h1234, r);
      rd(PRESCALE_OFS, d, r);
      check(d, 32'h1234);
      wr(PRESCALE_OFS, 32'h0, r);
      $display("test bus done");
   endtask

   // Free running at one edge per clock across a wrap
   task t_run;
      wr(CTRL_OFS, 32'h1f, r);
      @(negedge clk);
      p = countOut;
      s0 = stageCount;
      for (int i = 0; i < 16; i++) begin
         @(negedge clk);
         check(countOut, 4'(p + 4'h1));
         check(rippleCarry, countOut == 4'hf);
         p = countOut;
      end
      check(stageCount, 4'(s0 + 4'h1));
      wr(CTRL_OFS, 32'h03, r);
      rd(STATUS_OFS, d, r);
      check(d[8], 1'h1);
      check(d[4], 1'h0);
      wr(STATUS_OFS, 32'h100, r);
      rd(STATUS_OFS, d, r);
      check(d[8], 1'h0);
      wr(EVENTS_OFS, 32'h0, r);
      rd(EVENTS_OFS, d, r);
      check(d, 32'h0);
      $display("test run done");
   endtask

   task endSim;
      $display("checks %0d mismatches %0d", nTests, errTotal);
      if (errTotal == 0 && nTests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errTotal++;
      $display("[ERR] %0t watchdog expired", $time);
      endSim;
   end

   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'h1;
      repeat (3) @(posedge clk);
      t_reset;
      t_load;
      t_count;
      t_clear;
      t_short;
      t_async;
      t_bus;
      t_run;
      endSim;
   end
endmodule // presettable_binary_counter_4bit_tb_top
